// File: rtl/ids_regs.svh
`ifndef IDS_REGS_SVH
`define IDS_REGS_SVH

// Register indices; byte address is four times the index
`define IDS_DATA_IDX      8'hBC
`define IDS_STATE_IDX     8'hBD

// Reset values
`define IDS_DATA_RST      8'h00
`define IDS_STATE_RST     8'hF8

// State code field
`define IDS_CODE_MSB      7
`define IDS_CODE_LSB      3
`define IDS_IDLE_CODE     5'h1F
`define IDS_CODE_PAD      3'h0

// Bus answers
`define IDS_RESP_OKAY     2'h0
`define IDS_RESP_SLVERR   2'h2
`define IDS_RDATA_ZERO    32'h00000000

`endif

// File: rtl/ids_pkg.sv
package ids_pkg;

  typedef logic [7:0] ids_byte_t;

  typedef enum logic [2:0] {
    WR_COLLECT = 3'b001,
    WR_APPLY   = 3'b010,
    WR_RESP    = 3'b100
  } ids_wr_e;

endpackage

// File: rtl/ids_byte_shifter.sv
`timescale 1ns/10ps
`include "ids_regs.svh"

module ids_byte_shifter (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // Software load
  input  wire logic               loadEn,
  input  wire ids_pkg::ids_byte_t loadByte,
  // Bit shifting
  input  wire logic               shiftEn,
  input  wire logic               bitIn,
  input  wire logic               holdIn,
  // Held byte
  output ids_pkg::ids_byte_t      byteOut
);

  ids_pkg::ids_byte_t bus_data_byte_reg;
  ids_pkg::ids_byte_t bus_data_byte_next;
  wire                shiftGo;

  // Shifting stops while the event flag is up
  assign shiftGo = shiftEn && !holdIn;

  // Load wins over shift; shifted-in bit is the line, not the written bit
  assign bus_data_byte_next = loadEn  ? loadByte :
                              shiftGo ? {bus_data_byte_reg[6:0], bitIn} :
                                        bus_data_byte_reg;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      bus_data_byte_reg <= `IDS_DATA_RST;
    else
      bus_data_byte_reg <= bus_data_byte_next;
  end

  assign byteOut = bus_data_byte_reg;

  property p_hold_flag;
    @(posedge core_clk) disable iff (sys_rst)
    (holdIn && !loadEn) |=> (bus_data_byte_reg == $past(bus_data_byte_reg));
  endproperty
  a_hold_flag: assert property (p_hold_flag)
    else $error("Data byte changed while event flag set");

  property p_shift_in;
    @(posedge core_clk) disable iff (sys_rst)
    (shiftEn && !holdIn && !loadEn) |=>
      (bus_data_byte_reg[7:1] == $past(bus_data_byte_reg[6:0]));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("Data byte did not shift");

  property p_line_bit;
    @(posedge core_clk) disable iff (sys_rst)
    (shiftEn && !holdIn && !loadEn) |=> (bus_data_byte_reg[0] == $past(bitIn));
  endproperty
  a_line_bit: assert property (p_line_bit)
    else $error("Sampled line bit not captured");

endmodule

// File: rtl/ids_data_status.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "ids_regs.svh"

module ids_data_status (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write address
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Protocol engine side
  input  wire logic        shiftEn,
  input  wire logic        sdaSample,
  input  wire logic        stateLoad,
  input  wire logic [4:0]  stateCodeIn,
  input  wire logic        eventClear,
  output logic             sdaOut,
  output ids_pkg::ids_byte_t busByte,
  output logic             serialEvent,
  output logic             irqReq
);

  // Byte addresses of the two registers
  localparam logic [11:0] DATA_ADDR  = {2'b00, `IDS_DATA_IDX, 2'b00};
  localparam logic [11:0] STATE_ADDR = {2'b00, `IDS_STATE_IDX, 2'b00};

  ids_pkg::ids_wr_e   wrState_reg;
  ids_pkg::ids_wr_e   wrState_next;
  logic               awHeld_reg;
  logic               wHeld_reg;
  logic [11:0]        wrAddr_reg;
  logic [31:0]        wrData_reg;
  logic [3:0]         wrStrb_reg;
  logic               awready_reg;
  logic               wready_reg;
  logic               bvalid_reg;
  logic [1:0]         bresp_reg;
  logic               arready_reg;
  logic               rvalid_reg;
  logic [31:0]        rdata_reg;
  logic [1:0]         rresp_reg;
  logic               rdState_reg;
  logic [4:0]         bus_state_code_reg;
  logic               serialEvent_reg;
  logic               serialEvent_next;
  logic               irqReq_reg;
  ids_pkg::ids_byte_t dataByte;

  wire        awTake     = awvalid && awready_reg;
  wire        wTake      = wvalid && wready_reg;
  wire        arTake     = arvalid && arready_reg;
  wire        applying   = (wrState_reg == ids_pkg::WR_APPLY);
  wire        wrDataHit  = (wrAddr_reg == DATA_ADDR);
  wire        wrStateHit = (wrAddr_reg == STATE_ADDR);
  wire        wrMapped   = wrDataHit || wrStateHit;
  // Software byte load; no guard against a transfer in flight
  wire        dataLoad   = applying && wrDataHit && wrStrb_reg[0];
  wire        rdDataHit  = (araddr == DATA_ADDR);
  wire        rdStateHit = (araddr == STATE_ADDR);
  wire        codeIsIdle = (stateCodeIn == `IDS_IDLE_CODE);
  wire        eventSet   = stateLoad && !codeIsIdle;
  wire [7:0]  stateByte  = {bus_state_code_reg, `IDS_CODE_PAD};
  wire [31:0] rdMux      = rdDataHit  ? {24'h000000, dataByte} :
                           rdStateHit ? {24'h000000, stateByte} :
                                        `IDS_RDATA_ZERO;
  wire [1:0]  rdResp     = (rdDataHit || rdStateHit) ? `IDS_RESP_OKAY : `IDS_RESP_SLVERR;

  // Set wins over a clear in the same cycle
  assign serialEvent_next = eventSet ? 1'b1 : (eventClear ? 1'b0 : serialEvent_reg);

  always_comb
  begin
    wrState_next = wrState_reg;
    case (wrState_reg)
      ids_pkg::WR_COLLECT:
        if ((awHeld_reg || awTake) && (wHeld_reg || wTake))
          wrState_next = ids_pkg::WR_APPLY;
      ids_pkg::WR_APPLY:
        wrState_next = ids_pkg::WR_RESP;
      ids_pkg::WR_RESP:
        if (bready)
          wrState_next = ids_pkg::WR_COLLECT;
      default:
        wrState_next = ids_pkg::WR_COLLECT;
    endcase
  end

  // Write channel capture
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wrState_reg <= ids_pkg::WR_COLLECT;
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      wrAddr_reg  <= 12'h000;
      wrData_reg  <= 32'h00000000;
      wrStrb_reg  <= 4'h0;
    end
    else
    begin
      wrState_reg <= wrState_next;
      if (awTake)
      begin
        awHeld_reg  <= 1'b1;
        awready_reg <= 1'b0;
        wrAddr_reg  <= awaddr;
      end
      if (wTake)
      begin
        wHeld_reg  <= 1'b1;
        wready_reg <= 1'b0;
        wrData_reg <= wdata;
        wrStrb_reg <= wstrb;
      end
      if ((wrState_reg == ids_pkg::WR_RESP) && bready)
      begin
        awHeld_reg  <= 1'b0;
        wHeld_reg   <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `IDS_RESP_OKAY;
    end
    else if (applying)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wrMapped ? `IDS_RESP_OKAY : `IDS_RESP_SLVERR;
    end
    else if (bvalid_reg && bready)
      bvalid_reg <= 1'b0;
  end

  // Read channel
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= `IDS_RDATA_ZERO;
      rresp_reg   <= `IDS_RESP_OKAY;
      rdState_reg <= 1'b0;
    end
    else if (arTake)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rdMux;
      rresp_reg   <= rdResp;
      rdState_reg <= rdStateHit;
    end
    else if (rvalid_reg && rready)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // State code only moves with the protocol engine
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      bus_state_code_reg <= 5'(`IDS_STATE_RST >> `IDS_CODE_LSB);
    else if (stateLoad)
      bus_state_code_reg <= stateCodeIn;
  end

  // Event flag and interrupt request
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      serialEvent_reg <= 1'b0;
      irqReq_reg      <= 1'b0;
    end
    else
    begin
      serialEvent_reg <= serialEvent_next;
      irqReq_reg      <= eventSet;
    end
  end

  ids_byte_shifter u_shifter (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .loadEn   (dataLoad),
    .loadByte (wrData_reg[7:0]),
    .shiftEn  (shiftEn),
    .bitIn    (sdaSample),
    .holdIn   (serialEvent_reg),
    .byteOut  (dataByte)
  );

  assign awready     = awready_reg;
  assign wready      = wready_reg;
  assign bvalid      = bvalid_reg;
  assign bresp       = bresp_reg;
  assign arready     = arready_reg;
  assign rvalid      = rvalid_reg;
  assign rdata       = rdata_reg;
  assign rresp       = rresp_reg;
  assign sdaOut      = dataByte[7];
  assign busByte     = dataByte;
  assign serialEvent = serialEvent_reg;
  assign irqReq      = irqReq_reg;

  property p_code_load;
    @(posedge core_clk) disable iff (sys_rst)
    stateLoad |=> (bus_state_code_reg == $past(stateCodeIn));
  endproperty
  a_code_load: assert property (p_code_load)
    else $error("State code not loaded");

  property p_idle_quiet;
    @(posedge core_clk) disable iff (sys_rst)
    (stateLoad && codeIsIdle && !serialEvent_reg) |=> !serialEvent_reg;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("Idle code raised the event flag");

  property p_event_set;
    @(posedge core_clk) disable iff (sys_rst)
    (stateLoad && !codeIsIdle) |=> (serialEvent_reg && irqReq_reg);
  endproperty
  a_event_set: assert property (p_event_set)
    else $error("State entry missed flag or interrupt");

  property p_low_zero;
    @(posedge core_clk) disable iff (sys_rst)
    (rvalid_reg && rdState_reg) |-> (rdata_reg[2:0] == 3'h0 && rdata_reg[31:8] == 24'h000000);
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("State read has nonzero low bits");

  property p_ro_state;
    @(posedge core_clk) disable iff (sys_rst)
    (applying && wrStateHit && !stateLoad) |=> (bus_state_code_reg == $past(bus_state_code_reg));
  endproperty
  a_ro_state: assert property (p_ro_state)
    else $error("Software write changed state code");

  property p_write_resp;
    @(posedge core_clk) disable iff (sys_rst)
    (awTake && wTake && !awHeld_reg && !wHeld_reg) |=> ##1 bvalid_reg;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("Write response late");

  property p_read_resp;
    @(posedge core_clk) disable iff (sys_rst)
    arTake |=> (rvalid_reg && !arready_reg);
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("Read response late");

endmodule

// File: tb/ids_bus_model.sv
`timescale 1ns/10ps

module ids_bus_model (
  // Clock
  input  wire logic core_clk,
  // Line driven by the block
  input  wire logic sdaOut,
  // Engine strobes
  output logic       shiftEn,
  output logic       sdaSample,
  output logic       stateLoad,
  output logic [4:0] stateCodeIn,
  output logic       eventClear
);
  initial
  begin
    shiftEn = 1'b0;
    sdaSample = 1'b1;
    stateLoad = 1'b0;
    stateCodeIn = 5'h00;
    eventClear = 1'b0;
  end

  // One bit per two cycles, so sdaOut has settled
  task automatic bitOut(input logic andMask, input logic xorMask);
    @(posedge core_clk);
    shiftEn <= 1'b1;
    sdaSample <= (sdaOut & andMask) ^ xorMask; // Wired-AND line
    @(posedge core_clk);
    shiftEn <= 1'b0;
  endtask

  task automatic load(input logic [4:0] code);
    @(posedge core_clk);
    stateLoad <= 1'b1;
    stateCodeIn <= code;
    @(posedge core_clk);
    stateLoad <= 1'b0;
    stateCodeIn <= ~code;
  endtask

  task automatic xfer(input logic [7:0] other, input logic [4:0] code);
    for (int i = 7; i >= 0; i--)
      bitOut(other[i], 1'b0);
    // Released line rests high
    sdaSample <= 1'b1;
    load(code);
  endtask

  // Shifts that must be ignored while the event flag is up
  task automatic stray();
    for (int i = 0; i < 8; i++)
      bitOut(1'b1, 1'b1);
  endtask

  task automatic clear();
    @(posedge core_clk);
    eventClear <= 1'b1;
    @(posedge core_clk);
    eventClear <= 1'b0;
  endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps
`include "ids_regs.svh"

module tb_top;
  localparam logic [11:0] DataAddr  = {2'b00, `IDS_DATA_IDX, 2'b00};
  localparam logic [11:0] StateAddr = {2'b00, `IDS_STATE_IDX, 2'b00};
  localparam logic [11:0] BadAddr   = 12'h2F8;
  localparam logic [31:0] IdleWord  = {24'h000000, `IDS_STATE_RST};

  logic               core_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0]        awaddr, araddr;
  logic [31:0]        wdata;
  logic [3:0]         wstrb;
  wire logic          awready, wready, bvalid, arready, rvalid, sdaOut, serialEvent, irqReq;
  wire logic          shiftEn, sdaSample, stateLoad, eventClear;
  wire logic [1:0]    bresp, rresp;
  wire logic [31:0]   rdata;
  wire logic [4:0]    stateCodeIn;
  ids_pkg::ids_byte_t busByte;
  int                 errors, comparisons;
  logic [35:0]        expQ[$];
  logic [35:0]        seenV, expV;
  logic [7:0]         wByte, oByte;
  logic [4:0]         code;

  ids_data_status dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .shiftEn(shiftEn), .sdaSample(sdaSample),
    .stateLoad(stateLoad), .stateCodeIn(stateCodeIn), .eventClear(eventClear), .sdaOut(sdaOut),
    .busByte(busByte), .serialEvent(serialEvent), .irqReq(irqReq));

  ids_bus_model bm_u (.core_clk(core_clk), .sdaOut(sdaOut), .shiftEn(shiftEn), .sdaSample(sdaSample),
    .stateLoad(stateLoad), .stateCodeIn(stateCodeIn), .eventClear(eventClear));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic end_of_test;
    if (expQ.size() != 0)
      errors++;
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
    expQ.push_back({2'd0, r, 32'h00000000});
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'($urandom), d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] d);
    expQ.push_back({2'd1, r, d});
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Results arrive in order: bus answers and event pulses
  always @(posedge core_clk)
  begin
    if (!sys_rst && ((bvalid && bready) || (rvalid && rready) || irqReq))
    begin
      seenV = (bvalid && bready) ? {2'd0, bresp, 32'h00000000} :
              (rvalid && rready) ? {2'd1, rresp, rdata} : {2'd2, serialEvent, 1'b0, 24'h000000, busByte};
      expV = (expQ.size() != 0) ? expQ.pop_front() : '1;
      comparisons++;
      if (seenV !== expV)
      begin
        errors++;
        $display("MISMATCH result expected %h seen %h", expV, seenV);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test;
  end

  initial
  begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = '0;
    void'($urandom(94));
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(DataAddr, `IDS_RESP_OKAY, 32'h00000000);
    rd(StateAddr, `IDS_RESP_OKAY, IdleWord);
    rd(BadAddr, `IDS_RESP_SLVERR, `IDS_RDATA_ZERO);
    wr(StateAddr, 8'h07, 4'hF, `IDS_RESP_OKAY);
    rd(StateAddr, `IDS_RESP_OKAY, IdleWord);
    wr(BadAddr, 8'h5A, 4'hF, `IDS_RESP_SLVERR);
    wr(DataAddr, 8'hA5, 4'hF, `IDS_RESP_OKAY);
    wr(DataAddr, 8'h3C, 4'hE, `IDS_RESP_OKAY);
    rd(DataAddr, `IDS_RESP_OKAY, 32'h000000A5);
    for (int i = 0; i < 6; i++)
    begin
      wByte = (i == 0) ? 8'hFF : 8'($urandom);
      oByte = i[0] ? 8'hFF : 8'($urandom);
      code = 5'($urandom_range(30, 0));
      wr(DataAddr, wByte, 4'h1, `IDS_RESP_OKAY);
      expQ.push_back({2'd2, 2'b10, 24'h000000, wByte & oByte});
      bm_u.xfer(oByte, code);
      rd(StateAddr, `IDS_RESP_OKAY, {24'h000000, code, `IDS_CODE_PAD});
      bm_u.stray();
      rd(DataAddr, `IDS_RESP_OKAY, {24'h000000, wByte & oByte});
      bm_u.clear();
    end
    // State entry and flag clear on one edge: the set must win
    expQ.push_back({2'd2, 2'b10, 24'h000000, wByte & oByte});
    fork
      bm_u.load(code);
      bm_u.clear();
    join
    bm_u.clear();
    bm_u.load(`IDS_IDLE_CODE);
    rd(StateAddr, `IDS_RESP_OKAY, IdleWord);
    repeat (2) @(posedge core_clk);
    end_of_test;
  end
endmodule
